/* hw/hssc_pkg.sv */
// Constants and types for the halt, stall and status controller
package hssc_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_MIN_NS = 2000;
  // Least time, so round up to whole cycles
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = $clog2(RST_MIN_CYC + 1);
  // ------------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------------
  localparam int WDT_W = 12;
  localparam logic [WDT_W-1:0] WDT_LOAD = 12'hfff;
  localparam logic WDT_SRC_RST = 1'h0;
  // ------------------------------------------------------------------
  // Mode, wait bit and bus strobe
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MEMEXP = 2'h1;
  localparam logic [1:0] MODE_MICRO = 2'h2;
  localparam logic WAIT_BIT_RST = 1'h0;
  localparam int E_BASE_CYC = 1;
  localparam int E_STRETCH_CYC = 2 * E_BASE_CYC;
  localparam int E_CNT_W = 2;
  // ------------------------------------------------------------------
  // Write settle before a halt
  // ------------------------------------------------------------------
  localparam int NOP_SHORT_CYC = 1;
  localparam int NOP_STRETCH_CYC = 3;
  localparam int SETTLE_W = 2;
  // ------------------------------------------------------------------
  // Pin synchroniser slots
  // ------------------------------------------------------------------
  localparam int SYNC_N = 4;
  localparam int SY_RDY = 0;
  localparam int SY_HOLD = 1;
  localparam int SY_INT = 2;
  localparam int SY_RST = 3;
  typedef enum logic [2:0] {
    HSSC_RUN = 3'b000,
    HSSC_STOP = 3'b001,
    HSSC_WAKE = 3'b010,
    HSSC_WAIT = 3'b011,
    HSSC_HOLD = 3'b100
  } hssc_state_t;
endpackage

/* hw/hssc_wdt.sv */
// Twelve-bit down-counting watchdog, also used as the stop wake-up timer
`timescale 1ns/1ns
`default_nettype none
module hssc_wdt #(
  parameter int W = hssc_pkg::WDT_W
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic i_run,
  // Count state
  output logic [W-1:0] o_count,
  output logic o_zero
);
  import hssc_pkg::*;

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic zero_reg;
  logic zero_next;

  // Load wins over counting so a stop entry always starts from all ones
  always_comb begin
    count_next = count_reg;
    if (i_load) begin
      count_next = {W{1'b1}};
    end else if (i_run) begin
      count_next = count_reg - W'(1);
    end
    zero_next = (count_next == '0);
  end

  // Count registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      count_reg <= {W{1'b1}};
      zero_reg <= 1'b0;
    end else if (i_ce) begin
      count_reg <= count_next;
      zero_reg <= zero_next;
    end
  end

  assign o_count = count_reg;
  assign o_zero = zero_reg;
endmodule
`default_nettype wire

/* hw/hssc_ctrl.sv */
// Halt, stall and status controller: stop, wait, strobe stretch, ready, hold, reset
`timescale 1ns/1ns
`default_nettype none
module hssc_ctrl (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Core requests, same clock
  input wire logic [1:0] i_proc_mode,
  input wire logic i_stop_instruction,
  input wire logic i_wait_instruction,
  input wire logic i_wait_bit_wr,
  input wire logic i_wait_bit_wdata,
  input wire logic i_write,
  input wire logic i_write_ext_stretched,
  input wire logic i_ext_access,
  input wire logic i_int_req,
  input wire logic i_periph_wake,
  // Pins, asynchronous
  input wire logic i_ready_n,
  input wire logic i_hold_n,
  input wire logic i_ext_int_n,
  input wire logic i_reset_pin_n,
  // Clock and strobe status
  output logic o_osc_en,
  output logic o_phi_en,
  output logic o_e_strobe,
  output logic o_periph_en,
  output logic o_cpu_run,
  // Bus and ports
  output logic o_bus_freeze,
  output logic o_port_float,
  output logic o_p3_low,
  // Watchdog
  output logic o_wdt_run,
  output logic o_wdt_src_sys,
  output logic [hssc_pkg::WDT_W-1:0] o_wdt_count,
  // Status
  output logic o_wait_bit,
  output logic o_core_reset,
  output hssc_pkg::hssc_state_t o_state
);
  import hssc_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [SYNC_N-1:0] sync_q1;
  logic [SYNC_N-1:0] sync_q2;
  logic ext_mode;
  logic rdy_stall;
  logic hold_req;
  logic ext_wake;
  logic hw_int;
  logic wdt_load;
  logic wdt_zero;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic [RST_CNT_W-1:0] rst_cnt_next;
  logic core_rst_reg;
  logic core_rst_next;
  hssc_state_t st_reg;
  hssc_state_t st_next;
  logic [SETTLE_W-1:0] settle_reg;
  logic [SETTLE_W-1:0] settle_next;
  logic stop_pend_reg;
  logic stop_pend_next;
  logic wait_pend_reg;
  logic wait_pend_next;
  logic wait_bit_reg;
  logic wait_bit_next;
  logic src_sys_reg;
  logic src_sys_next;
  logic e_reg;
  logic e_next;
  logic [E_CNT_W-1:0] e_cnt_reg;
  logic [E_CNT_W-1:0] e_cnt_next;
  logic [E_CNT_W-1:0] e_last;
  logic e_go;
  logic stretch;
  logic osc_next;
  logic phi_next;
  logic run_next;
  logic freeze_next;
  logic float_next;
  logic wdt_run_next;
  logic osc_reg;
  logic phi_reg;
  logic run_reg;
  logic freeze_reg;
  logic float_reg;
  logic wdt_run_reg;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Two stages; only the second stage is read by logic
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync_q1 <= '1;
      sync_q2 <= '1;
    end else if (i_ce) begin
      sync_q1 <= {i_reset_pin_n, i_ext_int_n, i_hold_n, i_ready_n};
      sync_q2 <= sync_q1;
    end
  end

  // Qualified pin requests
  assign ext_mode = (i_proc_mode != MODE_SINGLE);
  assign rdy_stall = ext_mode && !sync_q2[SY_RDY];
  assign hold_req = ext_mode && !sync_q2[SY_HOLD];
  assign ext_wake = !sync_q2[SY_INT] || i_periph_wake;
  assign hw_int = i_int_req || !sync_q2[SY_INT];

  // ------------------------------------------------------------------
  // Reset pin filter
  // ------------------------------------------------------------------
  // Shorter glitches never reach the core; the count saturates while held
  always_comb begin
    rst_cnt_next = '0;
    core_rst_next = 1'b0;
    if (!sync_q2[SY_RST]) begin
      rst_cnt_next = rst_cnt_reg;
      if (rst_cnt_reg != RST_CNT_W'(RST_MIN_CYC)) begin
        rst_cnt_next = rst_cnt_reg + RST_CNT_W'(1);
      end
      core_rst_next = (rst_cnt_next == RST_CNT_W'(RST_MIN_CYC));
    end
  end

  // Reset filter registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rst_cnt_reg <= '0;
      core_rst_reg <= 1'b0;
    end else if (i_ce) begin
      rst_cnt_reg <= rst_cnt_next;
      core_rst_reg <= core_rst_next;
    end
  end

  // ------------------------------------------------------------------
  // Halt sequencing
  // ------------------------------------------------------------------
  // Priority: full reset, then hold, then ready stall, then halt entry
  always_comb begin
    st_next = st_reg;
    wdt_load = 1'b0;
    if (core_rst_reg) begin
      st_next = HSSC_RUN;
    end else begin
      unique case (st_reg)
        HSSC_RUN: begin
          if (hold_req) begin
            st_next = HSSC_HOLD;
          end else if (!rdy_stall && settle_reg == '0) begin
            if (stop_pend_reg) begin
              st_next = HSSC_STOP;
              wdt_load = 1'b1;
            end else if (wait_pend_reg) begin
              st_next = HSSC_WAIT;
            end
          end
        end
        HSSC_STOP: begin
          if (ext_wake) begin
            st_next = HSSC_WAKE;
          end
        end
        HSSC_WAKE: begin
          if (wdt_zero) begin
            st_next = HSSC_RUN;
          end
        end
        HSSC_WAIT: begin
          if (hw_int) begin
            st_next = HSSC_RUN;
          end
        end
        HSSC_HOLD: begin
          if (!hold_req) begin
            st_next = HSSC_RUN;
          end
        end
        default: st_next = HSSC_RUN;
      endcase
    end
  end

  // Pending halts, write settle, wait bit and count source select
  always_comb begin
    settle_next = settle_reg;
    if (i_write) begin
      settle_next = i_write_ext_stretched ? SETTLE_W'(NOP_STRETCH_CYC) :
                                            SETTLE_W'(NOP_SHORT_CYC);
    end else if (settle_reg != '0) begin
      settle_next = settle_reg - SETTLE_W'(1);
    end
    stop_pend_next = (stop_pend_reg || i_stop_instruction) && st_next != HSSC_STOP;
    wait_pend_next = (wait_pend_reg || i_wait_instruction) && st_next != HSSC_WAIT;
    wait_bit_next = i_wait_bit_wr ? i_wait_bit_wdata : wait_bit_reg;
    src_sys_next = src_sys_reg || wdt_load;
    if (core_rst_reg) begin
      settle_next = '0;
      stop_pend_next = 1'b0;
      wait_pend_next = 1'b0;
      wait_bit_next = WAIT_BIT_RST;
      src_sys_next = WDT_SRC_RST;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_reg <= HSSC_RUN;
      settle_reg <= '0;
      stop_pend_reg <= 1'b0;
      wait_pend_reg <= 1'b0;
      wait_bit_reg <= WAIT_BIT_RST;
      src_sys_reg <= WDT_SRC_RST;
    end else if (i_ce) begin
      st_reg <= st_next;
      settle_reg <= settle_next;
      stop_pend_reg <= stop_pend_next;
      wait_pend_reg <= wait_pend_next;
      wait_bit_reg <= wait_bit_next;
      src_sys_reg <= src_sys_next;
    end
  end

  // Watchdog doubles as the oscillator settle timer after a stop wake
  hssc_wdt #(
    .W(WDT_W)
  ) u_wdt (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_load(wdt_load),
    .i_run(wdt_run_reg),
    .o_count(o_wdt_count),
    .o_zero(wdt_zero)
  );

  // ------------------------------------------------------------------
  // Clock, bus, port and strobe status
  // ------------------------------------------------------------------
  // Outputs follow the next state so they change on the same edge as it
  always_comb begin
    osc_next = (st_next != HSSC_STOP);
    phi_next = (st_next != HSSC_STOP) && (st_next != HSSC_WAKE);
    run_next = (st_next == HSSC_RUN) && !rdy_stall;
    freeze_next = (st_next == HSSC_STOP) || (st_next == HSSC_WAKE) ||
                  (st_next == HSSC_WAIT) || (st_next == HSSC_RUN && rdy_stall);
    float_next = (st_next == HSSC_HOLD);
    wdt_run_next = (st_next == HSSC_RUN) || (st_next == HSSC_WAIT) ||
                   (st_next == HSSC_WAKE);
  end

  // Strobe: a frozen strobe keeps its level, a stretched phase lasts twice as long
  assign stretch = ext_mode && i_ext_access && !wait_bit_reg;
  assign e_last = stretch ? E_CNT_W'(E_STRETCH_CYC - 1) : E_CNT_W'(E_BASE_CYC - 1);
  assign e_go = !freeze_next && !float_next;
  always_comb begin
    e_next = e_reg;
    e_cnt_next = e_cnt_reg;
    if (float_next) begin
      e_next = 1'b1;
      e_cnt_next = '0;
    end else if (e_go) begin
      if (e_cnt_reg >= e_last) begin
        e_next = !e_reg;
        e_cnt_next = '0;
      end else begin
        e_cnt_next = e_cnt_reg + E_CNT_W'(1);
      end
    end
  end

  // Status registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      osc_reg <= 1'b1;
      phi_reg <= 1'b1;
      run_reg <= 1'b0;
      freeze_reg <= 1'b0;
      float_reg <= 1'b0;
      wdt_run_reg <= 1'b0;
      e_reg <= 1'b1;
      e_cnt_reg <= '0;
    end else if (i_ce) begin
      osc_reg <= osc_next;
      phi_reg <= phi_next;
      run_reg <= run_next;
      freeze_reg <= freeze_next;
      float_reg <= float_next;
      wdt_run_reg <= wdt_run_next;
      e_reg <= e_next;
      e_cnt_reg <= e_cnt_next;
    end
  end

  // Peripherals share the oscillator enable, so they stop only in stop mode
  assign o_osc_en = osc_reg;
  assign o_periph_en = osc_reg;
  assign o_phi_en = phi_reg;
  assign o_e_strobe = e_reg;
  assign o_cpu_run = run_reg;
  assign o_bus_freeze = freeze_reg;
  assign o_port_float = float_reg;
  assign o_p3_low = float_reg;
  assign o_wdt_run = wdt_run_reg;
  assign o_wdt_src_sys = src_sys_reg;
  assign o_wait_bit = wait_bit_reg;
  assign o_core_reset = core_rst_reg;
  assign o_state = st_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !i_ce);

  a_stop_clock_low: assert property (st_reg == HSSC_STOP |-> !o_phi_en && !o_osc_en)
    else $error("stop mode with clock running");
  a_stop_wdt_load: assert property (st_reg == HSSC_RUN && st_next == HSSC_STOP
    |=> o_wdt_count == WDT_LOAD && o_wdt_src_sys && !o_wdt_run)
    else $error("watchdog not loaded on stop entry");
  a_stop_exit_cause: assert property (st_reg == HSSC_STOP && !ext_wake && !core_rst_reg
    |=> st_reg == HSSC_STOP)
    else $error("stop left without a wake cause");
  a_wait_clocks_on: assert property (st_reg == HSSC_WAIT
    |-> o_osc_en && o_phi_en && o_wdt_run && o_bus_freeze && $stable(o_e_strobe))
    else $error("wait mode outputs wrong");
  a_wait_int_exit: assert property (st_reg == HSSC_WAIT && hw_int && !core_rst_reg
    |=> st_reg == HSSC_RUN && !o_bus_freeze)
    else $error("wait not left on interrupt");
  a_e_stretch_hold: assert property (e_go && stretch && e_cnt_reg == '0
    |=> $stable(o_e_strobe))
    else $error("stretched strobe phase too short");
  a_e_normal_width: assert property (e_go && !stretch |=> $changed(o_e_strobe))
    else $error("normal strobe phase not one cycle");
  a_single_no_hold: assert property (i_proc_mode == MODE_SINGLE && st_reg == HSSC_RUN
    |=> st_reg != HSSC_HOLD)
    else $error("hold honoured in single-chip mode");
  a_ready_freeze: assert property (st_reg == HSSC_RUN && rdy_stall && !hold_req && !core_rst_reg
    |=> $stable(o_e_strobe) && o_bus_freeze && o_phi_en && o_wdt_run && !o_cpu_run)
    else $error("ready stall outputs wrong");
  a_hold_ports: assert property (st_reg == HSSC_HOLD
    |-> o_e_strobe && o_port_float && o_p3_low && !o_wdt_run)
    else $error("hold outputs wrong");
  a_periph_osc: assert property (o_periph_en == (o_state != HSSC_STOP))
    else $error("peripherals disagree with oscillator");
  a_halt_settle: assert property (settle_reg != '0 && st_reg == HSSC_RUN
    |=> st_reg != HSSC_STOP && st_reg != HSSC_WAIT)
    else $error("halt entered before write settled");
  a_reset_length: assert property ($rose(o_core_reset)
    |-> $past(rst_cnt_reg) == RST_CNT_W'(RST_MIN_CYC - 1))
    else $error("core reset after wrong pin low time");
  a_reset_wait_bit: assert property (o_core_reset |=> !o_wait_bit)
    else $error("wait bit not cleared by reset");
  a_wake_settle: assert property (st_reg == HSSC_WAKE && !wdt_zero && !core_rst_reg
    |=> st_reg == HSSC_WAKE && !o_cpu_run)
    else $error("stop wake ended before count done");

  c_stop_wake_run: cover property (st_reg == HSSC_WAKE ##1 st_reg == HSSC_RUN);
  c_wait_exit: cover property (st_reg == HSSC_WAIT ##1 st_reg == HSSC_RUN);
  c_hold_cycle: cover property (st_reg == HSSC_HOLD ##1 st_reg == HSSC_RUN);
  c_ready_stall: cover property ((rdy_stall && st_reg == HSSC_RUN) [*3]);
endmodule
`default_nettype wire

/* sim/hssc_ext_party.sv */
// Far-side model: ready, hold, interrupt and reset pin drivers
`timescale 1ns/1ns
`default_nettype none
module hssc_ext_party (
  // Clock
  input wire logic i_clk,
  // Pins toward the controller
  output logic o_ready_n,
  output logic o_hold_n,
  output logic o_ext_int_n,
  output logic o_reset_pin_n
);
  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Pins idle high, as their pull-ups leave them
  initial begin
    o_ready_n = 1'h1;
    o_hold_n = 1'h1;
    o_ext_int_n = 1'h1;
    o_reset_pin_n = 1'h1;
  end
  // Ready level stays until this side drops the stall
  task automatic set_ready(input logic v);
    @(posedge i_clk);
    o_ready_n <= v;
  endtask
  // Hold request stays until this side gives the bus back
  task automatic set_hold(input logic v);
    @(posedge i_clk);
    o_hold_n <= v;
  endtask
  // Interrupt pin low for n cycles
  task automatic pulse_int(input int n);
    @(posedge i_clk);
    o_ext_int_n <= 1'h0;
    repeat (n) @(posedge i_clk);
    o_ext_int_n <= 1'h1;
  endtask
  // Reset pin low for n cycles; used for both short and long pulses
  task automatic pulse_reset(input int n);
    @(posedge i_clk);
    o_reset_pin_n <= 1'h0;
    repeat (n) @(posedge i_clk);
    o_reset_pin_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

/* sim/tb_halt_stall_status_control.sv */
// Self-checking bench for the halt, stall and status controller
`timescale 1ns/1ns
`default_nettype none
module tb_halt_stall_status_control;
  import hssc_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_ce = 1'h1;
  logic [1:0] i_proc_mode = 2'h0;
  logic i_stop_instruction = 1'h0;
  logic i_wait_instruction = 1'h0;
  logic i_wait_bit_wr = 1'h0;
  logic i_wait_bit_wdata = 1'h0;
  logic i_write = 1'h0;
  logic i_write_ext_stretched = 1'h0;
  logic i_ext_access = 1'h0;
  logic i_int_req = 1'h0;
  logic i_periph_wake = 1'h0;
  logic ready_n, hold_n, ext_int_n, reset_pin_n;
  logic o_osc_en, o_phi_en, o_e_strobe, o_periph_en, o_cpu_run;
  logic o_bus_freeze, o_port_float, o_p3_low, o_wdt_run, o_wdt_src_sys;
  logic [WDT_W-1:0] o_wdt_count;
  logic o_wait_bit, o_core_reset;
  hssc_state_t o_state;
  wire logic [7:0] stat;
  int fail_count = 0;
  int num_checks = 0;
  // Status patterns: osc, periph, phi, freeze, float, p3 low, wdt run, cpu run
  localparam logic [7:0] ST_RUN = 8'he3;
  localparam logic [7:0] ST_WAIT = 8'hf2;
  localparam logic [7:0] ST_RDY = 8'hf2;
  localparam logic [7:0] ST_STOP = 8'h10;
  localparam logic [7:0] ST_WAKE = 8'hd2;
  localparam logic [7:0] ST_HOLD = 8'hec;
  assign stat = {o_osc_en, o_periph_en, o_phi_en, o_bus_freeze, o_port_float, o_p3_low,
                 o_wdt_run, o_cpu_run};
  // 50 ns clock
  always #25 i_clk = ~i_clk;
  // ------------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------------
  hssc_ctrl dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_proc_mode(i_proc_mode),
    .i_stop_instruction(i_stop_instruction), .i_wait_instruction(i_wait_instruction),
    .i_wait_bit_wr(i_wait_bit_wr), .i_wait_bit_wdata(i_wait_bit_wdata), .i_write(i_write),
    .i_write_ext_stretched(i_write_ext_stretched), .i_ext_access(i_ext_access),
    .i_int_req(i_int_req), .i_periph_wake(i_periph_wake), .i_ready_n(ready_n),
    .i_hold_n(hold_n), .i_ext_int_n(ext_int_n), .i_reset_pin_n(reset_pin_n),
    .o_osc_en(o_osc_en), .o_phi_en(o_phi_en), .o_e_strobe(o_e_strobe),
    .o_periph_en(o_periph_en), .o_cpu_run(o_cpu_run), .o_bus_freeze(o_bus_freeze),
    .o_port_float(o_port_float), .o_p3_low(o_p3_low), .o_wdt_run(o_wdt_run),
    .o_wdt_src_sys(o_wdt_src_sys), .o_wdt_count(o_wdt_count), .o_wait_bit(o_wait_bit),
    .o_core_reset(o_core_reset), .o_state(o_state));
  hssc_ext_party ext_u (.i_clk(i_clk), .o_ready_n(ready_n), .o_hold_n(hold_n),
    .o_ext_int_n(ext_int_n), .o_reset_pin_n(reset_pin_n));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic complete_run();
    $display("fail_count=%0d num_checks=%0d", fail_count, num_checks);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic toggles(input int n, output int t);
    logic prev;
    t = 0;
    prev = o_e_strobe;
    repeat (n) begin
      tick(1);
      if (o_e_strobe !== prev) t++;
      prev = o_e_strobe;
    end
  endtask
  // Bounded wait; the last compare fails if the state never came
  task automatic wait_state(input hssc_state_t s, input int lim, output int c);
    c = 0;
    while (o_state !== s && c < lim) begin
      tick(1);
      c++;
    end
    chk(12'(o_state), 12'(s));
  endtask
  task automatic set_wbit(input logic v);
    @(posedge i_clk);
    i_wait_bit_wr <= 1'h1;
    i_wait_bit_wdata <= v;
    @(posedge i_clk);
    i_wait_bit_wr <= 1'h0;
    tick(1);
    chk(12'(o_wait_bit), 12'(v));
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_strobe();
    int t;
    @(posedge i_clk);
    i_proc_mode <= 2'h1;
    i_ext_access <= 1'h1;
    tick(3);
    toggles(8, t);
    chk(12'(t), 12'h004);
    @(posedge i_clk);
    i_ext_access <= 1'h0;
    tick(3);
    toggles(8, t);
    chk(12'(t), 12'h008);
    set_wbit(1'h1);
    @(posedge i_clk);
    i_ext_access <= 1'h1;
    tick(3);
    toggles(8, t);
    chk(12'(t), 12'h008);
    @(posedge i_clk);
    i_ext_access <= 1'h0;
  endtask
  // Wait in each processor mode, woken by an interrupt request
  task automatic t_wait();
    int m;
    int t;
    logic [11:0] w;
    for (m = 0; m < 3; m++) begin
      @(posedge i_clk);
      i_proc_mode <= 2'(m);
      i_wait_instruction <= 1'h1;
      @(posedge i_clk);
      i_wait_instruction <= 1'h0;
      tick(1);
      chk(12'(stat), 12'(ST_WAIT));
      w = o_wdt_count;
      toggles(8, t);
      chk(12'(t), 12'h000);
      chk(12'(o_wdt_count != w), 12'h001);
      // Enable low freezes the running watchdog as well
      @(posedge i_clk);
      i_ce <= 1'h0;
      #1;
      w = o_wdt_count;
      tick(3);
      chk(o_wdt_count, w);
      @(posedge i_clk);
      i_ce <= 1'h1;
      @(posedge i_clk);
      i_int_req <= 1'h1;
      @(posedge i_clk);
      i_int_req <= 1'h0;
      #1;
      chk(12'(o_state), 12'(HSSC_RUN));
    end
  endtask
  // Ready and hold in each mode; single-chip mode ignores both
  task automatic t_pins();
    int m;
    int h;
    int t;
    logic [7:0] e;
    for (m = 0; m < 3; m++) begin
      for (h = 0; h < 2; h++) begin
        @(posedge i_clk);
        i_proc_mode <= 2'(m);
        if (h == 1) ext_u.set_hold(1'h0);
        else ext_u.set_ready(1'h0);
        tick(4);
        e = (m == 0) ? ST_RUN : ((h == 1) ? ST_HOLD : ST_RDY);
        chk(12'(stat), 12'(e));
        toggles(8, t);
        chk(12'(t), (m == 0) ? 12'h008 : 12'h000);
        if (m != 0 && h == 1) chk(12'(o_e_strobe), 12'h001);
        if (h == 1) ext_u.set_hold(1'h1);
        else ext_u.set_ready(1'h1);
        tick(4);
        chk(12'(stat), 12'(ST_RUN));
      end
    end
  endtask
  // Stop, woken by the pin after a stretched write, else by a peripheral
  task automatic t_stop(input logic by_pin);
    int c;
    int t;
    @(posedge i_clk);
    i_write <= by_pin;
    i_write_ext_stretched <= by_pin;
    @(posedge i_clk);
    i_write <= 1'h0;
    i_write_ext_stretched <= 1'h0;
    i_stop_instruction <= 1'h1;
    // Peripheral run also leaves a wait pending behind the stop
    i_wait_instruction <= !by_pin;
    @(posedge i_clk);
    i_stop_instruction <= 1'h0;
    i_wait_instruction <= 1'h0;
    tick(1);
    if (by_pin) chk(12'(o_state), 12'(HSSC_RUN));
    else chk(12'(o_state), 12'(HSSC_STOP));
    wait_state(HSSC_STOP, 8, c);
    chk(12'(stat), 12'(ST_STOP));
    chk(12'({o_wdt_src_sys, 11'h000}), 12'h800);
    @(posedge i_clk);
    i_int_req <= 1'h1;
    toggles(8, t);
    chk(12'(t), 12'h000);
    chk(o_wdt_count, WDT_LOAD);
    chk(12'(o_state), 12'(HSSC_STOP));
    @(posedge i_clk);
    i_int_req <= 1'h0;
    i_periph_wake <= !by_pin;
    if (by_pin) ext_u.pulse_int(3);
    @(posedge i_clk);
    i_periph_wake <= 1'h0;
    #1;
    wait_state(HSSC_WAKE, 6, c);
    chk(12'(stat), 12'(ST_WAKE));
    wait_state(HSSC_RUN, 4300, c);
    chk(12'(c >= 4000), 12'h001);
    // Stop won over the wait; the wait runs once the core is back
    if (!by_pin) begin
      wait_state(HSSC_WAIT, 2, c);
      @(posedge i_clk);
      i_int_req <= 1'h1;
      @(posedge i_clk);
      i_int_req <= 1'h0;
    end
  endtask
  // Short reset pulse ignored, long one resets and clears the wait bit
  task automatic t_rstpin();
    int t;
    ext_u.pulse_reset(20);
    tick(3);
    chk(12'({o_core_reset, o_wait_bit}), 12'h001);
    ext_u.pulse_reset(45);
    #1;
    chk(12'(o_core_reset), 12'h001);
    tick(4);
    chk(12'({o_core_reset, o_wait_bit, o_wdt_src_sys}), 12'h000);
    @(posedge i_clk);
    i_proc_mode <= 2'h0;
    i_ext_access <= 1'h1;
    tick(3);
    toggles(8, t);
    chk(12'(t), 12'h008);
    @(posedge i_clk);
    i_proc_mode <= 2'h1;
    tick(3);
    toggles(8, t);
    chk(12'(t), 12'h004);
  endtask
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    #1;
    chk(o_wdt_count, WDT_LOAD);
    chk(12'({o_wait_bit, o_cpu_run}), 12'h000);
    @(posedge i_clk);
    i_rstn <= 1'h1;
    tick(2);
    t_strobe();
    t_wait();
    t_pins();
    t_stop(1'h1);
    t_stop(1'h0);
    t_rstpin();
    complete_run();
  end
  // Whole run is near 8600 cycles; over twice that means a hang
  initial begin
    #1_000_000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
